// >>> hdl/tsmc_edge_detect.sv
`timescale 1ns/100ps
// Registers a level and reports its rising edge and any transition.
module tsmc_edge_detect
  import tsmc_pkg::*;
#(
  parameter logic IDLE_LEVEL = TSMC_RST_LEVEL
)
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic level_in,
  output logic level_q,
  output logic rise,
  output logic toggle
);

  logic prev_q;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_q <= IDLE_LEVEL;
      prev_q <= IDLE_LEVEL;
    end
    else
    begin
      level_q <= level_in;
      prev_q <= level_q;
    end
  end

  assign rise = level_q & ~prev_q;
  assign toggle = level_q ^ prev_q;

endmodule // tsmc_edge_detect

// >>> hdl/tsmc_pkg.sv
package tsmc_pkg;

  // Slave mode field codes.
  typedef enum logic [2:0] {
    TSMC_SM_OFF     = 3'h0,
    TSMC_SM_ENC1    = 3'h1,
    TSMC_SM_ENC2    = 3'h2,
    TSMC_SM_ENC3    = 3'h3,
    TSMC_SM_RESET   = 3'h4,
    TSMC_SM_GATED   = 3'h5,
    TSMC_SM_TRIGGER = 3'h6,
    TSMC_SM_EXTCLK1 = 3'h7
  } tsmc_mode_t;

  // Trigger source field codes.
  localparam logic [2:0] TSMC_TS_INTERNAL_TRIGGER_ZERO = 3'h0;
  localparam logic [2:0] TSMC_TS_ITR1 = 3'h1;
  localparam logic [2:0] TSMC_TS_ITR2 = 3'h2;
  localparam logic [2:0] TSMC_TS_ITR3 = 3'h3;
  localparam logic [2:0] TSMC_TS_CH1ED = 3'h4;
  localparam logic [2:0] TSMC_TS_FILT1 = 3'h5;
  localparam logic [2:0] TSMC_TS_FILT2 = 3'h6;
  localparam logic [2:0] TSMC_TS_FILTERED_EXTERNAL_TRIGGER = 3'h7;

  // Values after reset.
  localparam logic TSMC_RST_LEVEL = 1'b0;

endpackage

// >>> hdl/tsmc_slave_ctrl.sv
`timescale 1ns/100ps
// Operation
// - Gated mode: counter advances only while selected trigger is high.
// - Gated mode: trigger low halts counting and keeps the count.
// - Gated mode: level controls start and stop; resumes from held value.
// - Trigger mode: rising trigger edge starts counting, count not cleared.
// - Trigger mode: trigger only starts; only clearing the run bit or leaving the mode stops counting.
// - External clock mode 1: one count per rising trigger edge.
// - Channel-1 edge detector pulses once per any filtered input transition.
// - Slave mode off: prescaler clocked from internal clock when run bit set.
// - Source codes: INTERNAL_TRIGGER_ZERO-3, edge pulse, filtered inputs 1/2, external trigger.
// - Reset mode: rising trigger edge reinitialises counter and raises update.
module tsmc_slave_ctrl
  import tsmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] slave_mode_field,
  input wire logic [2:0] trigger_source_field,
  input wire logic counter_run_bit,
  input wire logic internal_trigger_zero,
  input wire logic internal_trigger_one,
  input wire logic internal_trigger_two,
  input wire logic internal_trigger_three,
  input wire logic filtered_ch1_input,
  input wire logic filtered_ch2_input,
  input wire logic filtered_external_trigger,
  output logic count_tick,
  output logic counter_reinit,
  output logic update_event,
  output logic trigger_started,
  output logic selected_trigger_input
);

  ////////////////////////////////////////////////////////////////////////////////
  // Channel-1 edge detector and trigger selection.

  logic ch1_level_q;
  logic ch1_edge_pulse;

  tsmc_edge_detect u_ch1_edge (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level_in(filtered_ch1_input),
    .level_q(ch1_level_q),
    .rise(),
    .toggle(ch1_edge_pulse)
  );

  logic trig_mux;
  always_comb
  begin
    unique case (trigger_source_field)
      TSMC_TS_INTERNAL_TRIGGER_ZERO: trig_mux = internal_trigger_zero;
      TSMC_TS_ITR1: trig_mux = internal_trigger_one;
      TSMC_TS_ITR2: trig_mux = internal_trigger_two;
      TSMC_TS_ITR3: trig_mux = internal_trigger_three;
      TSMC_TS_CH1ED: trig_mux = ch1_edge_pulse;
      TSMC_TS_FILT1: trig_mux = ch1_level_q;
      TSMC_TS_FILT2: trig_mux = filtered_ch2_input;
      TSMC_TS_FILTERED_EXTERNAL_TRIGGER: trig_mux = filtered_external_trigger;
    endcase
  end

  // The selected trigger is registered and its edge found on ref_clk, so a
  // glitch during a source change costs at most one spurious edge.
  logic trig_level;
  logic trig_rise;

  tsmc_edge_detect u_trig_edge (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .level_in(trig_mux),
    .level_q(trig_level),
    .rise(trig_rise),
    .toggle()
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Mode decode.

  tsmc_mode_t mode;
  assign mode = tsmc_mode_t'(slave_mode_field);

  wire mode_off = (mode == TSMC_SM_OFF);
  wire mode_reset = (mode == TSMC_SM_RESET);
  wire mode_gated = (mode == TSMC_SM_GATED);
  wire mode_trig = (mode == TSMC_SM_TRIGGER);
  wire mode_ext1 = (mode == TSMC_SM_EXTCLK1);

  // Trigger mode latches its start; only leaving the mode or clearing the run
  // bit releases it.
  logic started_q;
  logic started_d;
  assign started_d = mode_trig & counter_run_bit & (started_q | trig_rise);

  // Encoder modes are outside this block and produce no tick here.
  wire tick_d = counter_run_bit & (
      (mode_off) |
      (mode_reset) |
      (mode_gated & trig_level) |
      (mode_trig & started_d) |
      (mode_ext1 & trig_rise));

  wire reinit_d = mode_reset & trig_rise;

  ////////////////////////////////////////////////////////////////////////////////
  // Output registers. The count itself lives outside; a missing tick holds it.

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      started_q <= TSMC_RST_LEVEL;
      count_tick <= TSMC_RST_LEVEL;
      counter_reinit <= TSMC_RST_LEVEL;
      update_event <= TSMC_RST_LEVEL;
      trigger_started <= TSMC_RST_LEVEL;
      selected_trigger_input <= TSMC_RST_LEVEL;
    end
    else
    begin
      started_q <= started_d;
      count_tick <= tick_d;
      counter_reinit <= reinit_d;
      update_event <= reinit_d;
      trigger_started <= started_d;
      selected_trigger_input <= trig_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  sequence s_trig_rise_ext1;
    mode_ext1 && counter_run_bit && trig_rise;
  endsequence

  sequence s_trig_start;
    mode_trig && counter_run_bit && !started_q && trig_rise;
  endsequence

  AST_GATED_HIGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_gated && counter_run_bit && trig_level |=> count_tick)
    else $error("gated mode did not tick with trigger high");

  AST_GATED_LOW: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_gated && !trig_level |=> !count_tick && !counter_reinit)
    else $error("gated mode ticked or cleared with trigger low");

  AST_GATED_RESUME: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_gated && counter_run_bit && $rose(trig_level) |=> count_tick && !counter_reinit)
    else $error("gated mode did not resume on trigger high");

  AST_TRIG_START: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_trig_start |=> count_tick && trigger_started && !counter_reinit)
    else $error("trigger mode did not start on rising edge");

  AST_TRIG_HOLD: assert property (@(posedge ref_clk) disable iff (!rst_n)
    started_q && mode_trig && counter_run_bit |=> count_tick [*1])
    else $error("trigger mode stopped while started");

  AST_EXT1_TICK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_trig_rise_ext1 |=> count_tick ##1 !count_tick)
    else $error("external clock mode tick not one per edge");

  AST_EDGE_PULSE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    filtered_ch1_input != ch1_level_q |=> ch1_edge_pulse)
    else $error("edge detector missed a transition");

  AST_OFF_TICK: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_off |=> count_tick == $past(counter_run_bit))
    else $error("slave off tick does not follow run bit");

  AST_SOURCE_SEL: assert property (@(posedge ref_clk) disable iff (!rst_n)
    trigger_source_field == TSMC_TS_FILT2 |=> trig_level == $past(filtered_ch2_input))
    else $error("trigger source select wrong");

  AST_RESET_MODE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_reset && trig_rise |=> counter_reinit && update_event)
    else $error("reset mode missed reinit on rising edge");

  // The sampled history must lie after reset, or the forced low of the edge
  // register would look like a missed or invented edge.
  AST_SYNC_EDGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(rst_n, 2) |-> trig_rise == ($past(trig_mux) && !$past(trig_mux, 2)))
    else $error("trigger edge not synchronous");

  AST_RUN_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !counter_run_bit |=> !count_tick)
    else $error("tick without run bit");

  AST_EDGE_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    filtered_ch1_input == ch1_level_q |=> !ch1_edge_pulse)
    else $error("edge detector pulsed without a transition");

  AST_TRIG_NO_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_trig |=> !counter_reinit)
    else $error("trigger mode reinitialised the counter");

  AST_TRIG_KEEP: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_trig && counter_run_bit && started_q |=> trigger_started)
    else $error("trigger mode lost its start");

  AST_EXT1_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mode_ext1 && !trig_rise |=> !count_tick)
    else $error("external clock mode ticked without an edge");

  AST_SOURCE_EDGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    trigger_source_field == TSMC_TS_CH1ED |=> trig_level == $past(ch1_edge_pulse))
    else $error("edge pulse source select wrong");

  AST_SOURCE_FILT1: assert property (@(posedge ref_clk) disable iff (!rst_n)
    trigger_source_field == TSMC_TS_FILT1 |=> trig_level == $past(ch1_level_q))
    else $error("channel-1 source select wrong");

  AST_RESET_QUIET: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(mode_reset && trig_rise) |=> !counter_reinit && !update_event)
    else $error("reinit or update without a reset-mode edge");

endmodule // tsmc_slave_ctrl

// >>> test/tb.sv
`timescale 1ns/100ps
module tb;
  import tsmc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] mode = 3'h0;
  logic [2:0] src = 3'h0;
  logic run = 1'b0;
  logic lvl = 1'b0;
  logic [6:0] lines;
  logic tick, reinit, upd;
  logic started, trig_sel;
  logic [5:0] h = 6'h00;
  logic st = 1'b0;
  logic [4:0] note;
  logic [4:0] expq[$];
  int num_errors = 0;
  int compares = 0;

  always #2 ref_clk = ~ref_clk;

  tsmc_trig_src_model src_u (.ref_clk(ref_clk), .rst_n(rst_n), .sel(src), .level(lvl),
    .trig_lines(lines));
  tsmc_slave_ctrl dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .slave_mode_field(mode),
    .trigger_source_field(src), .counter_run_bit(run), .internal_trigger_zero(lines[0]),
    .internal_trigger_one(lines[1]), .internal_trigger_two(lines[2]),
    .internal_trigger_three(lines[3]), .filtered_ch1_input(lines[4]),
    .filtered_ch2_input(lines[5]), .filtered_external_trigger(lines[6]),
    .count_tick(tick), .counter_reinit(reinit), .update_event(upd),
    .trigger_started(started), .selected_trigger_input(trig_sel));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_tick(input logic got, input logic exp);
    compares++;
    num_errors += (got !== exp);
    if (got !== exp) $display("ERROR %0t tick %b not %b m%0d s%0d", $time, got, exp, mode, src);
  endtask

  task automatic chk_pulse(input logic got_r, input logic got_u, input logic exp);
    compares++;
    num_errors += ({got_r, got_u} !== {exp, exp});
    if ({got_r, got_u} !== {exp, exp})
      $display("ERROR %0t reinit/update %b%b", $time, got_r, got_u);
  endtask

  task automatic chk_start(input logic got, input logic exp);
    compares++;
    num_errors += (got !== exp);
    if (got !== exp)
      $display("ERROR %0t started %b not %b m%0d s%0d", $time, got, exp, mode, src);
  endtask

  task automatic chk_trig(input logic got, input logic exp);
    compares++;
    num_errors += (got !== exp);
    if (got !== exp)
      $display("ERROR %0t trigger copy %b not %b s%0d", $time, got, exp, src);
  endtask

  // Level as the slave logic sees it; the edge pulse and channel-1 paths are a cycle later.
  function automatic logic ev(input int o);
    case (src)
      3'h4: return h[3+o] ^ h[4+o];
      3'h5: return h[3+o];
      default: return h[2+o];
    endcase
  endfunction

  task automatic step(input bit v);
    logic t, r, k;
    @(posedge ref_clk);
    t = v & 1'($urandom);
    lvl <= t;
    h = {h[4:0], t};
    r = ev(0) & ~ev(1);
    st = st | (run & r & (mode == 3'h6));
    case (mode)
      3'h0, 3'h4: k = run;
      3'h5: k = run & ev(0);
      3'h6: k = st;
      3'h7: k = run & r;
      default: k = 1'b0;
    endcase
    expq.push_back({v, k, (mode == 3'h4) & r, st, ev(0)});
  endtask

  always @(negedge ref_clk)
    if (expq.size() > 0)
    begin
      note = expq.pop_front();
      if (note[4]) chk_tick(tick, note[3]);
      if (note[4]) chk_pulse(reinit, upd, note[2]);
      if (note[4]) chk_start(started, note[1]);
      if (note[4]) chk_trig(trig_sel, note[0]);
    end

  task automatic end_sim();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Sources are switched with slave mode off and the trigger parked low, so the
  // channel-1 pipeline settles before a mode can see a stale edge from the old source.
  initial
  begin
    void'($urandom(73));
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int r = 0; r < 2; r++)
      for (int m = 0; m < 8; m++)
        for (int s = 0; s < 8; s++)
          if (!(m == 5 && s == 4))
          begin
            repeat (6) step(1'b0);
            @(posedge ref_clk);
            mode <= 3'h0;
            src <= 3'(s);
            run <= r[0];
            st = 1'b0;
            repeat (6) step(1'b0);
            @(posedge ref_clk);
            mode <= 3'(m);
            repeat (3) step(1'b0);
            repeat (40) step(1'b1);
          end
    repeat (4) @(posedge ref_clk);
    end_sim();
  end

  // The sweep needs about 7,200 cycles; this limit leaves ample margin.
  initial
  begin
    #100000;
    num_errors++;
    end_sim();
  end
endmodule // tb

// >>> test/tsmc_trig_src_model.sv
`timescale 1ns/100ps
module tsmc_trig_src_model
  import tsmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] sel,
  input wire logic level,
  output logic [6:0] trig_lines
);
  logic [6:0] noise_q;
  logic [6:0] pick;

  // Unselected sources toggle every cycle, so a wrong select shows up as stray ticks.
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      noise_q <= 7'h55;
    else
      noise_q <= ~noise_q;

  // Codes 4 and 5 both take the channel-1 line; lines 0-3 internal, 5 ch2, 6 external.
  assign pick = (sel < 3'h4) ? (7'h01 << sel) : (sel == 3'h7) ? 7'h40 :
    (sel == 3'h6) ? 7'h20 : 7'h10;
  assign trig_lines = (pick & {7{level}}) | (~pick & noise_q);
endmodule // tsmc_trig_src_model
